// ### rtl/sidc_cfg.svh
/*
 Constants of the maintenance command handler: command codes, response lengths,
 checksum parameters and command durations.
 Assumes a 100 MHz clock; included by bare name.
*/
`ifndef SIDC_CFG_SVH
`define SIDC_CFG_SVH
`define SIDC_CMD_GET_ID 16'h3682
`define SIDC_CMD_SELFTEST 16'h3639
`define SIDC_CMD_RESTORE 16'h3632
`define SIDC_LEN_ID 4'h9
`define SIDC_LEN_SELFTEST 4'h3
`define SIDC_CRC_POLY 8'h31
`define SIDC_CRC_INIT 8'hFF
`define SIDC_CLK_MHZ 100
`define SIDC_T_ID_MS 1
`define SIDC_T_SELFTEST_MS 5500
`define SIDC_T_RESTORE_MS 1200
`define SIDC_CYC_ID (`SIDC_T_ID_MS * 1000 * `SIDC_CLK_MHZ)
`define SIDC_CYC_SELFTEST (`SIDC_T_SELFTEST_MS * 1000 * `SIDC_CLK_MHZ)
`define SIDC_CYC_RESTORE (`SIDC_T_RESTORE_MS * 1000 * `SIDC_CLK_MHZ)
`endif

// ### rtl/sidc_pkg.sv
/*
 Types shared by the maintenance command handler.
 Assumes nothing of its surroundings.
*/
package sidc_pkg;
    // Command word from the bus target front end.
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } sidc_cmd_t;
    // Read byte answer toward the bus target front end.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } sidc_rbyte_t;
    typedef enum logic [1:0] {SIDC_OP_NONE, SIDC_OP_ID, SIDC_OP_SELFTEST, SIDC_OP_RESTORE}
        sidc_op_t;
endpackage : sidc_pkg

// ### rtl/sidc_crc8.sv
/*
 Checksum over one data word, combinational.
 Assumes the word is presented most significant byte first.
*/
`timescale 1ns/10ps
`include "sidc_cfg.svh"
module sidc_crc8 (
    // Data word in.
    input wire logic [15:0] word,
    // Checksum out.
    output logic [7:0] crc
);
    // Bitwise shift over both bytes, high byte first.
    always_comb begin
        logic [7:0] c;
        c = `SIDC_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ word[i]) begin
                c = {c[6:0], 1'b0} ^ `SIDC_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule : sidc_crc8

// ### rtl/sidc_cmd_handler.sv
/*
 Handler for three maintenance commands: read identifier, self check and restore
 defaults. It sits behind a bus target front end that delivers 16-bit command
 words and asks for read bytes one at a time, drives the self check engine through
 simple start and done signals, and pulses the start of the nonvolatile restore engine.
 Assumes all inputs are synchronous to clk.
*/
// Functional notes
// - Command 0x3682 makes the identifier readable within 1 ms.
// - The identifier reply is nine bytes, three words each followed by its checksum.
// - The words go out most significant first so they form the 48-bit identifier.
// - Command 0x3639 runs a self check including supply and waits 5500 ms.
// - The self check reply is one result word plus checksum, zero meaning no fault.
// - Command 0x3632 restores nonvolatile defaults within 1200 ms with no reply.
// - Restore also clears forced_recalibration and automatic_baseline_correction history.
// - Each checksum is CRC-8 with polynomial 0x31, init 0xFF, over the two prior bytes.
`timescale 1ns/10ps
`include "sidc_cfg.svh"
module sidc_cmd_handler #(
    parameter logic [47:0] UNIQUE_ID = 48'h0123_4567_89AB, // Arbitrary value.
    parameter int unsigned CYC_ID = `SIDC_CYC_ID,
    parameter int unsigned CYC_SELFTEST = `SIDC_CYC_SELFTEST,
    parameter int unsigned CYC_RESTORE = `SIDC_CYC_RESTORE
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Command words from the target front end.
    input wire sidc_pkg::sidc_cmd_t cmd,
    // Read byte handshake with the target front end.
    input wire logic rd_req,
    output logic rd_ack,
    output sidc_pkg::sidc_rbyte_t rd_byte,
    output logic busy,
    // Self check engine.
    output logic selftest_start,
    input wire logic selftest_done,
    input wire logic [15:0] selftest_result,
    // Nonvolatile restore engine.
    output logic restore_start,
    output logic clear_forced_recalibration,
    output logic clear_automatic_baseline_correction
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_READY} sidc_state_t;

    sidc_state_t state_r;
    sidc_pkg::sidc_op_t op_r;
    logic [31:0] timer_r;
    logic [15:0] result_r;
    logic st_done_r;
    logic [3:0] idx_r;
    logic [3:0] len_r;
    logic [15:0] cur_word;
    logic [7:0] cur_crc;
    logic [1:0] word_sel;
    logic [7:0] byte_val;

    // A word index from a byte index: three bytes per word.
    function automatic logic [1:0] word_of(input logic [3:0] idx);
        word_of = (idx < 4'h3) ? 2'h0 : (idx < 4'h6) ? 2'h1 : 2'h2;
    endfunction : word_of

    // Read is accepted only with a reply pending and no command running.
    // A frozen clock enable or a new command word declines it, so no byte is lost.
    assign rd_ack = ce && rd_req && !cmd.valid && (state_r == ST_READY);
    assign busy = (state_r == ST_EXEC);

    // Word currently being sent, high word of the identifier first.
    assign word_sel = word_of(idx_r);
    always_comb begin
        cur_word = result_r;
        if (op_r == sidc_pkg::SIDC_OP_ID) begin
            unique case (word_sel)
                2'h0: cur_word = UNIQUE_ID[47:32];
                2'h1: cur_word = UNIQUE_ID[31:16];
                default: cur_word = UNIQUE_ID[15:0];
            endcase
        end
    end

    sidc_crc8 u_crc (
        .word(cur_word),
        .crc(cur_crc)
    );

    // Byte within the word, checksum after each word.
    always_comb begin
        unique case (idx_r - 4'(word_sel) * 4'h3)
            4'h0: byte_val = cur_word[15:8];
            4'h1: byte_val = cur_word[7:0];
            default: byte_val = cur_crc;
        endcase
    end

    // Command decode, execution timing and reply bookkeeping.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            op_r <= sidc_pkg::SIDC_OP_NONE;
            timer_r <= 32'h0;
            idx_r <= 4'h0;
            len_r <= 4'h0;
            result_r <= 16'h0;
            st_done_r <= 1'b0;
        end else if (ce) begin
            if (cmd.valid && state_r != ST_EXEC) begin
                // Command words carry no checksum, so they act at once.
                idx_r <= 4'h0;
                unique case (cmd.word)
                    `SIDC_CMD_GET_ID: begin
                        state_r <= ST_EXEC;
                        op_r <= sidc_pkg::SIDC_OP_ID;
                        timer_r <= 32'(CYC_ID - 1);
                        len_r <= `SIDC_LEN_ID;
                    end
                    `SIDC_CMD_SELFTEST: begin
                        state_r <= ST_EXEC;
                        op_r <= sidc_pkg::SIDC_OP_SELFTEST;
                        timer_r <= 32'(CYC_SELFTEST - 1);
                        len_r <= `SIDC_LEN_SELFTEST;
                        st_done_r <= 1'b0;
                        result_r <= 16'hFFFF;
                    end
                    `SIDC_CMD_RESTORE: begin
                        state_r <= ST_EXEC;
                        op_r <= sidc_pkg::SIDC_OP_RESTORE;
                        timer_r <= 32'(CYC_RESTORE - 1);
                        len_r <= 4'h0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        op_r <= sidc_pkg::SIDC_OP_NONE;
                    end
                endcase
            end else if (state_r == ST_EXEC) begin
                if (op_r == sidc_pkg::SIDC_OP_SELFTEST && selftest_done && !st_done_r) begin
                    result_r <= selftest_result;
                    st_done_r <= 1'b1;
                end
                if (timer_r != 32'h0) begin
                    timer_r <= timer_r - 32'h1;
                end else if (op_r == sidc_pkg::SIDC_OP_RESTORE) begin
                    state_r <= ST_IDLE;
                end else begin
                    state_r <= ST_READY;
                end
            end else if (rd_ack) begin
                idx_r <= idx_r + 4'h1;
                if (idx_r + 4'h1 == len_r) begin
                    state_r <= ST_IDLE;
                end
            end
        end
    end

    // Read data register and engine start pulses.
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_byte <= '0;
            selftest_start <= 1'b0;
            restore_start <= 1'b0;
            clear_forced_recalibration <= 1'b0;
            clear_automatic_baseline_correction <= 1'b0;
        end else if (ce) begin
            rd_byte.valid <= rd_ack;
            rd_byte.data <= rd_ack ? byte_val : 8'h00;
            rd_byte.last <= rd_ack && (idx_r + 4'h1 == len_r);
            selftest_start <= cmd.valid && state_r != ST_EXEC
                && cmd.word == `SIDC_CMD_SELFTEST;
            restore_start <= cmd.valid && state_r != ST_EXEC
                && cmd.word == `SIDC_CMD_RESTORE;
            clear_forced_recalibration <= cmd.valid && state_r != ST_EXEC
                && cmd.word == `SIDC_CMD_RESTORE;
            clear_automatic_baseline_correction <= cmd.valid && state_r != ST_EXEC
                && cmd.word == `SIDC_CMD_RESTORE;
        end
    end

    // Named steps of a command.
    sequence s_id_cmd;
        ce && cmd.valid && state_r != ST_EXEC && cmd.word == `SIDC_CMD_GET_ID;
    endsequence
    sequence s_restore_cmd;
        ce && cmd.valid && state_r != ST_EXEC && cmd.word == `SIDC_CMD_RESTORE;
    endsequence

    a_read_declined_busy: assert property (@(posedge clk) disable iff (srst)
        busy |-> !rd_ack) else $error("Read accepted while busy.");
    a_restore_pulses: assert property (@(posedge clk) disable iff (srst)
        s_restore_cmd |=> restore_start && clear_forced_recalibration
            && clear_automatic_baseline_correction) else $error("Restore pulses missing.");
    a_restore_no_reply: assert property (@(posedge clk) disable iff (srst)
        s_restore_cmd |=> busy && len_r == 4'h0) else $error("Restore offers reply.");
    a_id_busy: assert property (@(posedge clk) disable iff (srst)
        s_id_cmd |=> busy && len_r == 4'h9) else $error("Identifier command not started.");
    a_selftest_start: assert property (@(posedge clk) disable iff (srst)
        selftest_start |-> $past(cmd.word) == `SIDC_CMD_SELFTEST && busy)
        else $error("Self check started wrongly.");
    a_id_first_byte: assert property (@(posedge clk) disable iff (srst)
        rd_ack && op_r == sidc_pkg::SIDC_OP_ID && idx_r == 4'h0
            |=> rd_byte.valid && rd_byte.data == UNIQUE_ID[47:40])
        else $error("Identifier high byte wrong.");
    a_crc_byte: assert property (@(posedge clk) disable iff (srst)
        rd_ack && idx_r == 4'h2 |=> rd_byte.data == $past(cur_crc))
        else $error("Checksum byte wrong.");
    a_reply_length: assert property (@(posedge clk) disable iff (srst)
        rd_ack && op_r == sidc_pkg::SIDC_OP_ID && idx_r == 4'h8 |=> rd_byte.last)
        else $error("Identifier reply length wrong.");
    a_selftest_len: assert property (@(posedge clk) disable iff (srst)
        rd_ack && op_r == sidc_pkg::SIDC_OP_SELFTEST && idx_r == 4'h2 |=> rd_byte.last)
        else $error("Self check reply length wrong.");

    // No read is taken while nothing is pending.
    a_read_declined_idle: assert property (@(posedge clk) disable iff (srst)
        state_r == ST_IDLE |-> !rd_ack) else $error("Read accepted with no reply pending.");

    // The self check result goes out high byte first.
    a_selftest_result: assert property (@(posedge clk) disable iff (srst)
        rd_ack && op_r == sidc_pkg::SIDC_OP_SELFTEST && idx_r == 4'h0
            |=> rd_byte.valid && rd_byte.data == result_r[15:8])
        else $error("Self check result byte wrong.");

    // A low clock enable holds the command state, its timer and the reply position.
    a_freeze_hold: assert property (@(posedge clk) disable iff (srst)
        !ce |=> $stable(state_r) && $stable(timer_r) && $stable(idx_r))
        else $error("State moved while clock enable low.");
endmodule : sidc_cmd_handler

// ### dv/sidc_ctrl_model.sv
/*
 Bus controller model: hands bare command words and read requests to the handler.
 Assumes the handler samples its inputs on the rising edge of clk.
*/
`timescale 1ns/10ps
module sidc_ctrl_model (
    // Clock.
    input wire logic clk,
    // Command word toward the handler.
    output sidc_pkg::sidc_cmd_t cmd,
    // Read byte handshake.
    output logic rd_req,
    input wire logic rd_ack,
    input wire sidc_pkg::sidc_rbyte_t rd_byte
);
    // Idle outputs from time zero.
    initial begin
        cmd = '0;
        rd_req = 1'b0;
    end
    // Sends a bare word for one cycle, then shows its inverse so stale data is never reused.
    task automatic send_cmd(input logic [15:0] w);
        @(negedge clk);
        cmd <= {1'b1, w};
        @(negedge clk);
        cmd <= {1'b0, ~w};
    endtask : send_cmd
    // Asks for one byte and returns the acceptance and the answer of the next cycle.
    task automatic read_byte(output logic a, output sidc_pkg::sidc_rbyte_t b);
        @(negedge clk);
        rd_req = 1'b1;
        #1 a = rd_ack;
        @(negedge clk);
        rd_req = 1'b0;
        b = rd_byte;
    endtask : read_byte
endmodule : sidc_ctrl_model

// ### dv/sidc_cmd_handler_tb_top.sv
/*
 Self-checking bench of the maintenance command handler with shortened durations.
 Assumes the controller model of this folder; the engines are played by the bench.
*/
`timescale 1ns/10ps
module sidc_cmd_handler_tb_top;
    localparam logic [47:0] ID = 48'hA5C3_0F1E_7D20; // Arbitrary value.
    localparam int CYC_ID_TB = 20;
    localparam int CYC_ST_TB = 50;
    localparam int CYC_RS_TB = 30;
    logic clk = 1'b0;
    logic ce = 1'b1;
    logic srst = 1'b1;
    logic st_done = 1'b0;
    logic [15:0] st_res = 16'h0000;
    logic rd_req, rd_ack, busy, st_start, rs_start, clr_f, clr_a;
    sidc_pkg::sidc_cmd_t cmd;
    sidc_pkg::sidc_rbyte_t rd_byte;
    int fail_count = 0, checked = 0, n_st = 0, n_rs = 0, n_cf = 0, n_ca = 0;
    // Clock of 10 ns.
    always #5 clk = ~clk;
    sidc_cmd_handler #(.UNIQUE_ID(ID), .CYC_ID(CYC_ID_TB), .CYC_SELFTEST(CYC_ST_TB),
        .CYC_RESTORE(CYC_RS_TB)) dut (
        .clk(clk), .srst(srst), .ce(ce), .cmd(cmd), .rd_req(rd_req), .rd_ack(rd_ack),
        .rd_byte(rd_byte), .busy(busy), .selftest_start(st_start), .selftest_done(st_done),
        .selftest_result(st_res), .restore_start(rs_start),
        .clear_forced_recalibration(clr_f), .clear_automatic_baseline_correction(clr_a));
    sidc_ctrl_model ctrl (.clk(clk), .cmd(cmd), .rd_req(rd_req), .rd_ack(rd_ack),
        .rd_byte(rd_byte));
    // Counts the one-cycle pulses toward the engines.
    always @(posedge clk) begin
        n_st += (st_start === 1'b1);
        n_rs += (rs_start === 1'b1);
        n_cf += (clr_f === 1'b1);
        n_ca += (clr_a === 1'b1);
    end
    // Bitwise checksum, most significant bit first.
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // Waits a bounded time for the command to finish.
    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && busy !== 1'b0; i++) @(negedge clk);
        chk({15'h0000, busy}, 16'h0000);
    endtask : wait_idle
    task automatic no_read();
        logic a;
        sidc_pkg::sidc_rbyte_t b;
        ctrl.read_byte(a, b);
        chk({15'h0000, a}, 16'h0000);
    endtask : no_read
    // Reads one word and its checksum, checking flags on every byte.
    task automatic get_word(input logic [15:0] w, input logic fin);
        logic a;
        sidc_pkg::sidc_rbyte_t b;
        logic [7:0] e [3];
        e = '{w[15:8], w[7:0], crc8(w)};
        for (int k = 0; k < 3; k++) begin
            ctrl.read_byte(a, b);
            chk({a, b.valid, b.last, 5'h00, b.data}, {2'b11, fin && k == 2, 5'h00, e[k]});
        end
    endtask : get_word
    task automatic t_id();
        ctrl.send_cmd(16'h3682);
        chk({15'h0000, busy}, 16'h0001);
        no_read();
        wait_idle(30);
        for (int w = 0; w < 3; w++) get_word(ID[47 - 16 * w -: 16], w == 2);
        no_read();
        $display("test id done");
    endtask : t_id
    task automatic t_self(input logic [15:0] res);
        int s0;
        s0 = n_st;
        ctrl.send_cmd(16'h3639);
        repeat (5) @(negedge clk);
        chk(16'(n_st - s0), 16'h0001);
        no_read();
        ctrl.send_cmd(16'h3682);
        st_res = res;
        st_done = 1'b1;
        wait_idle(70);
        st_done = 1'b0;
        get_word(res, 1'b1);
        no_read();
        $display("test self check done");
    endtask : t_self
    task automatic t_rst();
        int r0, f0, a0;
        r0 = n_rs;
        f0 = n_cf;
        a0 = n_ca;
        ctrl.send_cmd(16'h3682);
        wait_idle(30);
        ctrl.send_cmd(16'h3632);
        wait_idle(40);
        chk(16'(n_rs - r0), 16'h0001);
        chk({8'(n_cf - f0), 8'(n_ca - a0)}, 16'h0101);
        no_read();
        $display("test restore done");
    endtask : t_rst
    // Freezes the identifier command mid-run and a pending read, then reads it all.
    task automatic t_freeze();
        ctrl.send_cmd(16'h3682);
        ce = 1'b0;
        repeat (25) @(negedge clk);
        chk({15'h0000, busy}, 16'h0001);
        ce = 1'b1;
        wait_idle(30);
        ce = 1'b0;
        no_read();
        ce = 1'b1;
        for (int w = 0; w < 3; w++) get_word(ID[47 - 16 * w -: 16], w == 2);
        no_read();
        $display("test clock enable done");
    endtask : t_freeze
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // Main sequence after a reset of 12 cycles.
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_id();
        t_self(16'h0000);
        t_self(16'h0005);
        t_rst();
        t_freeze();
        give_verdict();
    end
    // Watchdog at about seventeen times the expected run of some 300 cycles.
    initial begin
        #50000;
        fail_count++;
        give_verdict();
    end
endmodule : sidc_cmd_handler_tb_top
